// *** rtl/i2cs_top.sv ***
// Two-wire serial port: slave engine, bus condition flags, register file
// Function
// - After START, shift eight bits on SCL rise
// - Eighth falling edge compares upper seven bits
// - Match with room loads buffer, ACKs, flags
// - Data byte always flags; load, ACK conditional
// - Ten-bit first byte 11110, A9, A8, write
// - Ten-bit address byte sets UA, holds SCL
// - Buffer read clears full; software clears flag
// - Repeated START high byte accepted without UA
// - Write address clears R/W, loads buffer
// - Address during overflow gets no ACK
// - Every received data byte raises the flag
// - Read address sets R/W, ACKs, stretches
// - Buffer write loads shifter; release frees SCL
// - Transmit changes SDA on falls, flags ninth
// - Master ACK latched ninth rise; NACK ends
// - START/STOP bits toggle, cleared when off
// - Direction bit output drives line low
// - Master-support mode 1011 flags START, STOP, bytes
// - Busy bus flags when STOP arrives in modes 1011, 1110, 1111
// - Slave keeps receiving after lost arbitration
// - Clock release high frees SCL, low stretches
// - Mode codes 0110,0111,1110,1111,1011
//
// Implementation choice: the strobed register port.
module i2cs_top
   import i2cs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe
);

   // ****************************************
   // Pin sampling
   // ****************************************
   logic [1:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       c_rise;
   logic       c_fall;
   logic       c_start;
   logic       c_stop;

   i2cs_sync u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({scl_in, sda_in}),
      .q     (pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   i2cs_cond u_cond (
      .clk      (clk),
      .rst_b    (rst_b),
      .scl      (scl_s),
      .sda      (sda_s),
      .scl_rise (c_rise),
      .scl_fall (c_fall),
      .start    (c_start),
      .stop     (c_stop)
   );

   // ****************************************
   // State
   // ****************************************
   i2cs_top_t  r;
   i2cs_top_t  n;
   logic [3:0] mode;
   logic       live;
   logic       hit;

   assign mode = r.ctrl[3:0];
   assign live = r.ctrl[B_EN] && is_i2c(mode);

   always_comb begin
      n       = r;
      hit     = 1'b0;
      n.rdata = 8'h00;
      // ****************************************
      // Register reads
      // ****************************************
      if (rd) begin
         case (addr)
            OFF_GLOBAL_INTERRUPT_CONTROL: n.rdata = r.global_interrupt_control;
            OFF_PERIPHERAL_IRQ_FLAGS:   n.rdata = r.peripheral_irq_flags;
            OFF_BUF:    n.rdata = r.buffer;
            OFF_CTRL:   n.rdata = r.ctrl;
            OFF_DIR:    n.rdata = r.dir;
            OFF_PERIPHERAL_IRQ_ENABLES:   n.rdata = r.peripheral_irq_enables;
            OFF_ADDR:   n.rdata = r.oaddr;
            OFF_STAT:   n.rdata = {r.smp_cke, r.d_a, r.p, r.s, r.rw, r.ua, r.bf};
            default:    n.rdata = 8'h00;
         endcase
         if (addr == OFF_BUF) begin
            n.bf = 1'b0;
         end
      end
      // ****************************************
      // Register writes
      // ****************************************
      if (wr) begin
         case (addr)
            OFF_GLOBAL_INTERRUPT_CONTROL: n.global_interrupt_control = wdata;
            OFF_PERIPHERAL_IRQ_FLAGS:   n.peripheral_irq_flags = wdata;
            OFF_CTRL:   n.ctrl = wdata;
            OFF_DIR:    n.dir = wdata;
            OFF_PERIPHERAL_IRQ_ENABLES:   n.peripheral_irq_enables = wdata;
            OFF_STAT:   n.smp_cke = wdata[7:6];
            OFF_ADDR: begin
               n.oaddr = wdata;
               n.ua    = 1'b0;
            end
            OFF_BUF: begin
               n.buffer = wdata;
               if (r.st == S_TX && r.cnt == 4'h0) begin
                  n.shift = wdata;
                  n.tx_ld = 1'b1;
                  n.bf    = 1'b1;
               end else if (r.st == S_TX || r.st == S_MACK) begin
                  n.ctrl[B_WCOL] = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // ****************************************
      // Bus engine; hardware sets come last so they win
      // ****************************************
      if (!live) begin
         n.st        = S_IDLE;
         n.p         = 1'b0;
         n.s         = 1'b0;
         n.ack_drive = 1'b0;
         n.ten_ok    = 1'b0;
      end else if (c_start) begin
         n.s         = 1'b1;
         n.p         = 1'b0;
         n.st        = S_RX;
         n.cnt       = 4'h0;
         n.is_addr   = 1'b1;
         n.ten_lo    = 1'b0;
         n.ack_drive = 1'b0;
         if (is_ssirq(mode)) begin
            n.peripheral_irq_flags[B_IRQ] = 1'b1;
         end
      end else if (c_stop) begin
         n.p         = 1'b1;
         n.s         = 1'b0;
         n.st        = S_IDLE;
         n.ten_ok    = 1'b0;
         n.ack_drive = 1'b0;
         if (is_ssirq(mode)) begin
            n.peripheral_irq_flags[B_IRQ] = 1'b1;
         end
      end else begin
         unique case (r.st)
            S_IDLE: ;
            S_RX: begin
               if (c_rise && r.cnt < BITS_BYTE) begin
                  n.shift = {r.shift[6:0], sda_s};
                  n.cnt   = r.cnt + 4'h1;
               end else if (c_fall && r.cnt == BITS_BYTE) begin
                  n.st       = S_ACK;
                  n.pend_irq = 1'b0;
                  n.pend_ua  = 1'b0;
                  n.pend_tx  = 1'b0;
                  if (mode == M_MAST) begin
                     n.pend_irq = 1'b1;
                  end else if (!r.is_addr) begin
                     n.pend_irq  = 1'b1;
                     n.d_a       = 1'b1;
                     n.ack_drive = !r.bf && !r.ctrl[B_OV];
                     if (!r.bf) begin
                        n.buffer = r.shift;
                        n.bf     = 1'b1;
                     end else begin
                        n.ctrl[B_OV] = 1'b1;
                     end
                  end else begin
                     // high byte pattern held in own address
                     if (is_ten(mode) && r.ten_lo) begin
                        hit = (r.shift == r.oaddr);
                     end else begin
                        hit = (r.shift[7:1] == r.oaddr[7:1]);
                     end
                     if (is_ten(mode) && !r.ten_lo && r.shift[0] && !r.ten_ok) begin
                        hit = 1'b0;
                     end
                     if (!hit) begin
                        n.st = S_IDLE;
                     end else if (r.bf || r.ctrl[B_OV]) begin
                        n.ctrl[B_OV] = 1'b1;
                        n.st         = S_IDLE;
                     end else begin
                        n.buffer    = r.shift;
                        n.bf        = 1'b1;
                        n.ack_drive = 1'b1;
                        n.pend_irq  = 1'b1;
                        n.d_a       = 1'b0;
                        if (!is_ten(mode)) begin
                           n.rw      = r.shift[0];
                           n.pend_tx = r.shift[0];
                           n.is_addr = 1'b0;
                        end else if (r.ten_lo) begin
                           n.pend_ua = 1'b1;
                           n.ten_lo  = 1'b0;
                           n.ten_ok  = 1'b1;
                           n.is_addr = 1'b0;
                           n.rw      = 1'b0;
                        end else if (r.shift[0]) begin
                           n.rw      = 1'b1;
                           n.pend_tx = 1'b1;
                           n.is_addr = 1'b0;
                        end else begin
                           n.pend_ua = 1'b1;
                           n.ten_lo  = 1'b1;
                           n.rw      = 1'b0;
                        end
                     end
                  end
               end
            end
            S_ACK: begin
               if (c_fall) begin
                  n.ack_drive = 1'b0;
                  n.cnt       = 4'h0;
                  if (r.pend_irq) begin
                     n.peripheral_irq_flags[B_IRQ] = 1'b1;
                  end
                  if (r.pend_ua) begin
                     n.ua = 1'b1;
                  end
                  if (r.pend_tx) begin
                     n.st          = S_TX;
                     n.tx_ld       = 1'b0;
                     n.ctrl[B_CKP] = 1'b0;
                  end else begin
                     n.st = S_RX;
                  end
               end
            end
            S_TX: begin
               if (c_fall && r.tx_ld) begin
                  n.shift = {r.shift[6:0], 1'b1};
                  n.cnt   = r.cnt + 4'h1;
                  if (r.cnt == BITS_BYTE - 4'h1) begin
                     n.st    = S_MACK;
                     n.tx_ld = 1'b0;
                  end
               end
            end
            S_MACK: begin
               if (c_rise && sda_s) begin
                  n.st      = S_IDLE;
                  n.rw      = 1'b0;
                  n.d_a     = 1'b0;
                  n.ua      = 1'b0;
                  n.bf      = 1'b0;
                  n.smp_cke = 2'h0;
               end else if (c_fall) begin
                  n.peripheral_irq_flags[B_IRQ] = 1'b1;
                  n.ctrl[B_CKP] = 1'b0;
                  n.d_a         = 1'b1;
                  n.bf          = 1'b0;
                  n.cnt         = 4'h0;
                  n.st          = S_TX;
               end
            end
            default: n.st = S_IDLE;
         endcase
      end
      // ****************************************
      // Open-drain pins, always low when driven
      // ****************************************
      n.scl_out = 1'b0;
      n.sda_out = 1'b0;
      n.scl_oe = !n.dir[B_SCL] || (n.ctrl[B_EN] && is_slave(n.ctrl[3:0])
                 && (!n.ctrl[B_CKP] || n.ua));
      n.sda_oe = !n.dir[B_SDA] || (n.st == S_ACK && n.ack_drive)
                 || (n.st == S_TX && n.tx_ld && !n.shift[7]);
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         r <= TOP_RST;
      end else begin
         r <= n;
      end
   end

   assign rdata   = r.rdata;
   assign scl_out = r.scl_out;
   assign scl_oe  = r.scl_oe;
   assign sda_out = r.sda_out;
   assign sda_oe  = r.sda_oe;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   logic quiet;
   assign quiet = live && !c_start && !c_stop;

   a_start_flags:
   assert property (live && c_start |=> r.s && !r.p) else $error("start not recorded");
   a_stop_flags:
   assert property (live && c_stop |=> r.p && !r.s) else $error("stop not recorded");
   a_off_clear:
   assert property (!r.ctrl[B_EN] |=> !r.p && !r.s) else $error("flags kept while off");
   a_sample_bit:
   assert property (quiet && r.st == S_RX && c_rise && r.cnt < BITS_BYTE
                    |=> r.shift[0] == $past(sda_s) && r.cnt == $past(r.cnt) + 4'h1)
      else $error("bit not sampled");
   a_ack_drive:
   assert property (r.st == S_ACK && r.ack_drive |-> sda_oe) else $error("ack not driven");
   a_irq_ninth:
   assert property (quiet && r.st == S_ACK && c_fall && r.pend_irq |=> r.peripheral_irq_flags[B_IRQ])
      else $error("flag missing on ninth fall");
   a_ua_hold:
   assert property (r.ua && r.ctrl[B_EN] && is_slave(mode) |-> scl_oe)
      else $error("clock not held for address update");
   a_buf_read:
   assert property (rd && addr == OFF_BUF && !wr && r.st != S_RX |=> !r.bf)
      else $error("buffer read left full set");
   a_read_stretch:
   assert property (quiet && r.st == S_ACK && c_fall && r.pend_tx
                    |=> r.st == S_TX && !r.ctrl[B_CKP] ##0 scl_oe)
      else $error("read address not stretched");
   a_nack_end:
   assert property (quiet && r.st == S_MACK && c_rise && sda_s |=> r.st == S_IDLE && !r.rw)
      else $error("nack did not end transfer");
   a_dir_drive:
   assert property (!r.dir[B_SCL] |-> scl_oe) else $error("output direction not driving");

   c_tx_entry: cover property (r.st == S_ACK ##1 r.st == S_TX);
   c_ua_set: cover property (!r.ua ##1 r.ua);
   c_nack_end: cover property (r.st == S_MACK ##1 r.st == S_IDLE);
   c_stop_irq: cover property (live && c_stop && is_ssirq(mode));

endmodule : i2cs_top

// *** rtl/i2cs_pkg.sv ***
// Shared constants, types and decode helpers for the serial port block
package i2cs_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFF_GLOBAL_INTERRUPT_CONTROL = 8'h0b;
   localparam logic [7:0] OFF_PERIPHERAL_IRQ_FLAGS   = 8'h0c;
   localparam logic [7:0] OFF_BUF    = 8'h13;
   localparam logic [7:0] OFF_CTRL   = 8'h14;
   localparam logic [7:0] OFF_DIR    = 8'h87;
   localparam logic [7:0] OFF_PERIPHERAL_IRQ_ENABLES   = 8'h8c;
   localparam logic [7:0] OFF_ADDR   = 8'h93;
   localparam logic [7:0] OFF_STAT   = 8'h94;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int B_IRQ  = 3;
   localparam int B_WCOL = 7;
   localparam int B_OV   = 6;
   localparam int B_EN   = 5;
   localparam int B_CKP  = 4;
   localparam int B_SCL  = 3;
   localparam int B_SDA  = 4;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hff;
   localparam logic [3:0] BITS_BYTE = 4'h8;

   // ****************************************
   // Modes
   // ****************************************
   localparam logic [3:0] M_SL7   = 4'h6;
   localparam logic [3:0] M_SL10  = 4'h7;
   localparam logic [3:0] M_MAST  = 4'hb;
   localparam logic [3:0] M_SL7I  = 4'he;
   localparam logic [3:0] M_SL10I = 4'hf;

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_RX   = 5'h02,
      S_ACK  = 5'h04,
      S_TX   = 5'h08,
      S_MACK = 5'h10
   } i2cs_st_t;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
   } i2cs_sync_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } i2cs_cond_t;

   typedef struct packed {
      i2cs_st_t   st;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic       is_addr;
      logic       ten_lo;
      logic       ten_ok;
      logic       ack_drive;
      logic       pend_irq;
      logic       pend_ua;
      logic       pend_tx;
      logic       tx_ld;
      logic [7:0] global_interrupt_control;
      logic [7:0] peripheral_irq_flags;
      logic [7:0] peripheral_irq_enables;
      logic [7:0] buffer;
      logic [7:0] ctrl;
      logic [7:0] dir;
      logic [7:0] oaddr;
      logic [1:0] smp_cke;
      logic       d_a;
      logic       p;
      logic       s;
      logic       rw;
      logic       ua;
      logic       bf;
      logic [7:0] rdata;
      logic       scl_oe;
      logic       sda_oe;
      logic       scl_out;
      logic       sda_out;
   } i2cs_top_t;

   localparam i2cs_top_t TOP_RST = '{st: S_IDLE, dir: RST_DIR, default: '0};

   function automatic logic is_i2c(input logic [3:0] m);
      is_i2c = (m == M_SL7) || (m == M_SL10) || (m == M_MAST) || (m == M_SL7I) || (m == M_SL10I);
   endfunction : is_i2c

   function automatic logic is_slave(input logic [3:0] m);
      is_slave = is_i2c(m) && (m != M_MAST);
   endfunction : is_slave

   function automatic logic is_ten(input logic [3:0] m);
      is_ten = (m == M_SL10) || (m == M_SL10I);
   endfunction : is_ten

   function automatic logic is_ssirq(input logic [3:0] m);
      is_ssirq = (m == M_MAST) || (m == M_SL7I) || (m == M_SL10I);
   endfunction : is_ssirq

endpackage : i2cs_pkg

// *** rtl/i2cs_sync.sv ***
// Two-stage synchroniser for the clock and data pins
module i2cs_sync
   import i2cs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [1:0] d,
   output logic      [1:0] q
);

   // ****************************************
   // State
   // ****************************************
   i2cs_sync_t r;
   i2cs_sync_t next_r;

   // Idle bus level is high, so reset to high avoids a false edge
   always_comb begin
      next_r    = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         r <= '{s1: 2'h3, s2: 2'h3};
      end else begin
         r <= next_r;
      end
   end

   assign q = r.s2;

endmodule : i2cs_sync

// *** rtl/i2cs_cond.sv ***
// Edge and bus condition detector on synchronised clock and data lines
module i2cs_cond
   import i2cs_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_rise,
   output logic      scl_fall,
   output logic      start,
   output logic      stop
);

   // ****************************************
   // State
   // ****************************************
   i2cs_cond_t r;
   i2cs_cond_t next_r;

   always_comb begin
      next_r     = r;
      next_r.scl = scl;
      next_r.sda = sda;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         r <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   assign scl_rise = scl && !r.scl;
   assign scl_fall = !scl && r.scl;
   assign start    = scl && r.scl && r.sda && !sda;
   assign stop     = scl && r.scl && !r.sda && sda;

endmodule : i2cs_cond

// *** sim/i2cs_master_model.sv ***
// Behavioural two-wire bus master driving open-drain pull-low enables
module i2cs_master_model (
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_oe,
   output logic      sda_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HALF = 400;
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   task automatic wait_high();
      int n;
      n = 0;
      while (scl !== 1'b1 && n < 20000) begin
         #10;
         n++;
      end
   endtask : wait_high
   // Data moves only while the clock is low, sampled mid high phase
   task automatic bit_io(input logic b, output logic r);
      #(HALF / 2) sda_oe = ~b;
      #(HALF / 2) scl_oe = 1'b0;
      wait_high();
      #(HALF / 2) r = sda;
      #(HALF / 2) scl_oe = 1'b1;
   endtask : bit_io
   task automatic start();
      #37 sda_oe = 1'b0;
      #(HALF / 2) scl_oe = 1'b0;
      wait_high();
      #(HALF) sda_oe = 1'b1;
      #(HALF) scl_oe = 1'b1;
   endtask : start
   task automatic stop();
      #37 sda_oe = 1'b1;
      #(HALF / 2) scl_oe = 1'b0;
      wait_high();
      #(HALF) sda_oe = 1'b0;
      #(HALF);
   endtask : stop
   // Most significant bit first, ninth bit returns the acknowledge
   task automatic send(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], ack);
      end
      bit_io(1'b1, ack);
   endtask : send
   task automatic recv(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(nack, r);
   endtask : recv
endmodule : i2cs_master_model

// *** sim/i2cs_top_test.sv ***
// Self-checking bench for the two-wire serial port
module i2cs_top_test;
   import i2cs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk, rst_b, wr, rd, rd_d, ack;
   logic [7:0] addr, wdata, rdata, d0, d1, rx;
   logic       scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe;
   wire logic  scl_w, sda_w;
   int         bad_count, check_count, seed;
   logic [15:0] exp_q[$];
   localparam logic [7:0] REG_A [9] = '{OFF_GLOBAL_INTERRUPT_CONTROL, OFF_PERIPHERAL_IRQ_FLAGS, OFF_BUF, OFF_CTRL, OFF_DIR,
                                        OFF_PERIPHERAL_IRQ_ENABLES, OFF_ADDR, OFF_STAT, 8'h55};
   localparam logic [3:0] MODES [5] = '{M_SL7, M_SL10, M_MAST, M_SL7I, M_SL10I};
   // Released lines are pulled up
   assign scl_w = ~(scl_oe | m_scl_oe);
   assign sda_w = ~(sda_oe | m_sda_oe);
   i2cs_top i_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe));
   i2cs_master_model i_master (.scl(scl_w), .sda(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ****************************************
   // Compare, bus access and closing tasks
   // ****************************************
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back({e & m, m});
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask : reg_rd
   // Link answers trail the clock edge by a few system cycles
   task automatic settle();
      repeat (8) @(posedge clk);
   endtask : settle
   task automatic test_done();
      if (bad_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   // Read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      rd_d <= rd;
   end
   always @(negedge clk) begin
      logic [15:0] e;
      if (rd_d === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check("register read", e[15:8], rdata & e[7:0]);
      end
   end
   initial begin
      #3000000;
      bad_count++;
      test_done();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = 32'hde29;
      {addr, wdata, wr, rd, rd_d, rst_b} = '0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         reg_rd(REG_A[i], (i == 4) ? RST_DIR : RST_REG, 8'hff);
      end
      reg_wr(OFF_CTRL, 8'h36);
      reg_wr(OFF_ADDR, 8'ha0);
      reg_rd(OFF_CTRL, 8'h36, 8'hff);
      i_master.start();
      settle();
      reg_rd(OFF_STAT, 8'h08, 8'h18);
      i_master.send(8'ha0, ack);
      check("address ack", 8'h00, {7'h00, ack});
      settle();
      reg_rd(OFF_BUF, 8'ha0, 8'hff);
      reg_rd(OFF_PERIPHERAL_IRQ_FLAGS, 8'h08, 8'h08);
      reg_rd(OFF_STAT, 8'h08, 8'h2d);
      reg_wr(OFF_PERIPHERAL_IRQ_FLAGS, 8'h00);
      d0 = $random(seed);
      d1 = $random(seed);
      i_master.send(d0, ack);
      check("data ack", 8'h00, {7'h00, ack});
      i_master.send(d1, ack);
      check("full ack", 8'h01, {7'h00, ack});
      settle();
      reg_rd(OFF_PERIPHERAL_IRQ_FLAGS, 8'h08, 8'h08);
      reg_rd(OFF_CTRL, 8'h76, 8'hff);
      reg_rd(OFF_BUF, d0, 8'hff);
      reg_rd(OFF_STAT, 8'h28, 8'h29);
      i_master.start();
      i_master.send(8'ha0, ack);
      check("overflow ack", 8'h01, {7'h00, ack});
      i_master.stop();
      settle();
      reg_rd(OFF_STAT, 8'h10, 8'h18);
      reg_wr(OFF_CTRL, 8'h36);
      i_master.start();
      i_master.send(8'hb0, ack);
      check("foreign ack", 8'h01, {7'h00, ack});
      i_master.start();
      i_master.send(8'ha1, ack);
      check("read ack", 8'h00, {7'h00, ack});
      settle();
      check("clock hold", 8'h01, {7'h00, scl_oe});
      reg_rd(OFF_STAT, 8'h0d, 8'h0d);
      reg_rd(OFF_CTRL, 8'h26, 8'hff);
      d0 = $random(seed);
      reg_wr(OFF_BUF, d0);
      reg_wr(OFF_CTRL, 8'h36);
      i_master.recv(1'b1, rx);
      check("sent byte", d0, rx);
      settle();
      reg_rd(OFF_STAT, 8'h08, 8'h2f);
      i_master.stop();
      // Ten-bit write: high byte, software swaps in low byte, then swaps back
      reg_wr(OFF_CTRL, 8'h37);
      reg_wr(OFF_ADDR, 8'hf0);
      i_master.start();
      i_master.send(8'hf0, ack);
      check("high address ack", 8'h00, {7'h00, ack});
      settle();
      check("update hold", 8'h01, {7'h00, scl_oe});
      reg_rd(OFF_STAT, 8'h0b, 8'h0f);
      reg_rd(OFF_BUF, 8'hf0, 8'hff);
      reg_wr(OFF_ADDR, 8'h5a);
      i_master.send(8'h5a, ack);
      check("low address ack", 8'h00, {7'h00, ack});
      settle();
      reg_rd(OFF_STAT, 8'h0b, 8'h0f);
      reg_rd(OFF_BUF, 8'h5a, 8'hff);
      reg_wr(OFF_ADDR, 8'hf0);
      i_master.stop();
      foreach (MODES[i]) begin
         reg_wr(OFF_CTRL, {4'h3, MODES[i]});
         reg_wr(OFF_PERIPHERAL_IRQ_FLAGS, 8'h00);
         i_master.start();
         i_master.stop();
         settle();
         reg_rd(OFF_PERIPHERAL_IRQ_FLAGS, (MODES[i] == 4'hb || MODES[i][3:2] == 2'b11) ? 8'h08 : 8'h00,
                8'h08);
      end
      reg_wr(OFF_CTRL, 8'h06);
      reg_rd(OFF_STAT, 8'h00, 8'h18);
      reg_wr(OFF_DIR, 8'he7);
      settle();
      check("pull low", 8'h03, {6'h00, scl_oe, sda_oe});
      reg_wr(OFF_DIR, 8'hff);
      repeat (3) @(posedge clk);
      test_done();
   end
endmodule : i2cs_top_test
